// *** logic/rtc_pkg.sv ***
package rtc_pkg;

    // ****************************************************
    // Register byte offsets on the APB bus.
    // ****************************************************
    localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_ALARM_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_TIME_VALUE    = 8'h08;
    localparam logic [7:0] ADDR_DATE_VALUE    = 8'h0c;
    localparam logic [7:0] ADDR_ALARM_TIME    = 8'h10;
    localparam logic [7:0] ADDR_ALARM_DATE    = 8'h14;
    localparam logic [7:0] ADDR_UNLOCK        = 8'h18;

    // ****************************************************
    // Field positions.
    // ****************************************************
    localparam int CC_ON_BIT    = 15;
    localparam int CC_SEL_BIT   = 7;
    localparam int CC_RUN_BIT   = 6;
    localparam int CC_WREN_BIT  = 3;
    localparam int CC_RSYNC_BIT = 2;
    localparam int CC_HALF_BIT  = 1;
    localparam int CC_OE_BIT    = 0;
    localparam int AC_EN_BIT    = 15;
    localparam int AC_CHIME_BIT = 14;
    localparam int AC_PIV_BIT   = 13;
    localparam int AC_SYNC_BIT  = 12;
    localparam int AC_MASK_LSB  = 8;
    localparam int AC_RPT_LSB   = 0;
    localparam int SEC_LSB      = 8;
    localparam int MIN_LSB      = 16;
    localparam int HR_LSB       = 24;
    localparam int WDAY_LSB     = 0;

    // ****************************************************
    // Reset values, keys and counts.
    // ****************************************************
    localparam logic [7:0]  RPT_RESET  = 8'h00;
    localparam logic [3:0]  MASK_RESET = 4'h0;
    localparam logic [31:0] UNLOCK_KEY1 = 32'h0000c35a;
    localparam logic [31:0] UNLOCK_KEY2 = 32'h0000a5c3;
    localparam logic [7:0]  RPT_LAST   = 8'h00;
    localparam logic [7:0]  RPT_WRAP   = 8'hff;
    localparam logic [3:0]  TENS_MAX_MS = 4'h5;
    localparam logic [3:0]  TENS_MAX_HR = 4'h2;
    localparam logic [3:0]  UNITS_MAX   = 4'h9;
    localparam int SYNC_TICKS          = 32;
    localparam int HALF_SEC_TICKS_DEF  = 16384;

    // Alarm interval codes.
    typedef enum logic [3:0] {
        MASK_HALF    = 4'h0,
        MASK_SEC     = 4'h1,
        MASK_TEN_SEC = 4'h2,
        MASK_MIN     = 4'h3,
        MASK_TEN_MIN = 4'h4,
        MASK_HOUR    = 4'h5,
        MASK_DAY     = 4'h6,
        MASK_WEEK    = 4'h7,
        MASK_MONTH   = 4'h8,
        MASK_YEAR    = 4'h9
    } mask_t;

    // Unlock sequence states.
    typedef enum logic [2:0] {
        LK_IDLE = 3'b001,
        LK_KEY1 = 3'b010,
        LK_OPEN = 3'b100
    } lock_t;

endpackage : rtc_pkg

// *** logic/rtc_sync2.sv ***
`timescale 1ns/1ns

// Two-stage synchroniser for a level from outside the clock domain.
module rtc_sync2
(
    input  wire logic ref_clk_in,
    input  wire logic rstn_in,
    input  wire logic d_in,
    output logic      q_out
);

    logic meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            meta_q <= 1'b0;
            q_out  <= 1'b0;
        end
        else
        begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end

endmodule : rtc_sync2

// *** logic/rtc_alarm_ctrl.sv ***
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ns

// What this block does and what its software must do
// R1: Time and date value writes take effect only while write enable is set.
// R2: Write enable can be set only after the unlock key sequence.
// R3: Module on bit changes only while write enable is set.
// R4: Read sync flag is high near a half-second rollover.
// R5: Software double-reads values while read sync flag is high.
// R6: Half-second flag is read-only, high in second half, cleared by time write.
// R7: Pin output active only with output enable set, else held low.
// R8: Control registers reset only by power-on reset.
// R9: Alarm enable clears on event when count is zero and chime off.
// R10: With chime the count wraps zero to all ones; else it stops.
// R11: Repeat count decrements on each alarm event while it is nonzero.
// R12: Pulse start level writable only while alarm is disabled.
// R13: Alarm sync flag high within 32 ticks of a half-second rollover.
// R14: Software rereads the repeat count until two reads agree.
// R15: Four-bit mask selects the alarm interval.
// R16: Yearly alarm on February 29 fires once every four years.
// R17: Software never programs reserved mask codes.
// R18: Software avoids alarm field writes while on and alarm sync high.
// R19: Alarm sync relies on reads shorter than 32 bus clocks.
// R20: Software skips the access right after clearing the on bit.
// R21: Alarm control bits 31 to 16 read as zero.
// R22: Time fields hold valid BCD digits.
// R23: Alarm event when the masked alarm fields match current time.
// R24: Time-base status is synchronised before software reads it.
module rtc_alarm_ctrl
    import rtc_pkg::*;
#(
    parameter int HALF_SEC_TICKS = HALF_SEC_TICKS_DEF
)
(
    input  wire logic        ref_clk_in,
    input  wire logic        rstn_in,
    input  wire logic        rtc_clk_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    input  wire logic [31:0] cal_time_in,
    input  wire logic [31:0] cal_date_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    output logic             rtc_pin_out,
    output logic             rtc_pin_oe_out,
    output logic             second_tick_out,
    output logic             time_load_out,
    output logic [31:0]      time_wdata_out,
    output logic             date_load_out,
    output logic [31:0]      date_wdata_out
);

    localparam int PW = $clog2(HALF_SEC_TICKS);

    if (HALF_SEC_TICKS <= 2 * SYNC_TICKS)
    begin : g_check
        $error("HALF_SEC_TICKS too small for the sync window");
    end

    // Checks one BCD byte against a tens limit.
    function automatic logic bcd_ok(input logic [7:0] v,
                                    input logic [3:0] tmax);
        bcd_ok = (v[7:4] <= tmax) && (v[3:0] <= UNITS_MAX);
    endfunction : bcd_ok

    // Checks the seconds, minutes and hours fields of a time word.
    function automatic logic time_ok(input logic [31:0] t);
        time_ok = bcd_ok(t[SEC_LSB+:8], TENS_MAX_MS)
                && bcd_ok(t[MIN_LSB+:8], TENS_MAX_MS)
                && bcd_ok(t[HR_LSB+:8], TENS_MAX_HR);
    endfunction : time_ok

    logic          rtc_clk_s;
    logic          rtc_prev_q;
    logic [PW-1:0] presc_q;
    logic          half_q;
    logic          on_q, sel_q, wren_q, oe_q;
    logic          en_q, chime_q, pulse_q;
    logic [3:0]    mask_q;
    logic [7:0]    rpt_q;
    logic [31:0]   atime_q, adate_q;
    lock_t         lock_q;
    logic [1:0]    roll_q, sec_q;
    logic          tick, roll, near, match, alarm_ev;
    logic          wr, cc_wr, ac_wr, tm_wr;
    logic [31:0]   rd;
    logic          rd_err;

    // ****************************************************
    // Time base and prescaler.
    // ****************************************************

    // The time-base pin is brought into the bus clock domain.
    rtc_sync2 u_sync ( // R24
        .ref_clk_in (ref_clk_in),
        .rstn_in    (rstn_in),
        .d_in       (rtc_clk_in),
        .q_out      (rtc_clk_s)
    );

    assign tick = rtc_clk_s & ~rtc_prev_q;
    assign roll = on_q && tick && (presc_q == PW'(HALF_SEC_TICKS - 1));
    // High while a rollover is at most SYNC_TICKS ticks away.
    assign near = on_q
               && (presc_q >= PW'(HALF_SEC_TICKS - SYNC_TICKS)); // R4 R13

    // The prescaler counts time-base ticks while the module is on.
    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rtc_prev_q <= 1'b0;
            presc_q    <= '0;
            half_q     <= 1'b0;
        end
        else
        begin
            rtc_prev_q <= rtc_clk_s;
            if (tm_wr)
            begin
                presc_q <= '0;
                half_q  <= 1'b0; // R6
            end
            else if (roll)
            begin
                presc_q <= '0;
                half_q  <= ~half_q; // R6
            end
            else if (on_q && tick)
                presc_q <= presc_q + PW'(1);
        end
    end

    // Rollover stages; the calendar updates one cycle after the tick.
    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            roll_q <= 2'b00;
            sec_q  <= 2'b00;
        end
        else
        begin
            roll_q <= {roll_q[0], roll};
            sec_q  <= {sec_q[0], roll & half_q};
        end
    end

    // ****************************************************
    // APB slave.
    // ****************************************************

    assign wr    = psel_in & penable_in & pwrite_in & pready_out;
    assign cc_wr = wr && (paddr_in == ADDR_CLOCK_CONTROL);
    assign ac_wr = wr && (paddr_in == ADDR_ALARM_CONTROL);
    assign tm_wr = wr && (paddr_in == ADDR_TIME_VALUE) && wren_q // R1
                && time_ok(pwdata_in); // R22

    // Read data mux; unused bits stay zero.
    always_comb
    begin
        rd     = '0; // R21
        rd_err = 1'b0;
        case (paddr_in)
            ADDR_CLOCK_CONTROL:
            begin
                rd[CC_ON_BIT]    = on_q;
                rd[CC_SEL_BIT]   = sel_q;
                rd[CC_RUN_BIT]   = on_q;
                rd[CC_WREN_BIT]  = wren_q;
                rd[CC_RSYNC_BIT] = near; // R4
                rd[CC_HALF_BIT]  = half_q; // R6
                rd[CC_OE_BIT]    = oe_q;
            end
            ADDR_ALARM_CONTROL:
            begin
                rd[AC_EN_BIT]      = en_q;
                rd[AC_CHIME_BIT]   = chime_q;
                rd[AC_PIV_BIT]     = pulse_q; // R12
                rd[AC_SYNC_BIT]    = near; // R13
                rd[AC_MASK_LSB+:4] = mask_q;
                rd[AC_RPT_LSB+:8]  = rpt_q;
            end
            ADDR_TIME_VALUE:  rd[31:8] = cal_time_in[31:8];
            ADDR_DATE_VALUE:
            begin
                rd[31:8]         = cal_date_in[31:8];
                rd[WDAY_LSB+:4]  = cal_date_in[WDAY_LSB+:4];
            end
            ADDR_ALARM_TIME:  rd = atime_q;
            ADDR_ALARM_DATE:  rd = adate_q;
            ADDR_UNLOCK:      rd = '0;
            default:          rd_err = 1'b1;
        endcase
    end

    // One wait-free access cycle: the answer is ready in the access phase.
    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= '0;
        end
        else
        begin
            pready_out  <= psel_in & ~penable_in;
            pslverr_out <= psel_in & ~penable_in & rd_err;
            prdata_out  <= (psel_in & ~penable_in & ~pwrite_in) ? rd : '0;
        end
    end

    // ****************************************************
    // Unlock sequence and clock control.
    // ****************************************************

    // Two key writes in a row open the lock for one control write.
    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            lock_q <= LK_IDLE;
        else if (wr && paddr_in == ADDR_UNLOCK)
        begin
            case (lock_q)
                LK_IDLE: lock_q <= (pwdata_in == UNLOCK_KEY1) ? LK_KEY1
                                                             : LK_IDLE;
                LK_KEY1: lock_q <= (pwdata_in == UNLOCK_KEY2) ? LK_OPEN
                                                             : LK_IDLE;
                default: lock_q <= LK_IDLE;
            endcase
        end
        else if (cc_wr)
            lock_q <= LK_IDLE;
    end

    // Clock control; reset only by the power-on reset.
    always_ff @(posedge ref_clk_in or negedge rstn_in) // R8
    begin
        if (!rstn_in)
        begin
            on_q   <= 1'b0;
            sel_q  <= 1'b0;
            wren_q <= 1'b0;
            oe_q   <= 1'b0;
        end
        else if (cc_wr)
        begin
            sel_q <= pwdata_in[CC_SEL_BIT];
            oe_q  <= pwdata_in[CC_OE_BIT];
            if (wren_q)
                on_q <= pwdata_in[CC_ON_BIT]; // R3
            if (!pwdata_in[CC_WREN_BIT] || lock_q == LK_OPEN)
                wren_q <= pwdata_in[CC_WREN_BIT]; // R2
        end
    end

    // Value writes are handed to the calendar as one-cycle loads.
    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            time_load_out  <= 1'b0;
            date_load_out  <= 1'b0;
            time_wdata_out <= '0;
            date_wdata_out <= '0;
        end
        else
        begin
            time_load_out <= tm_wr; // R1
            date_load_out <= wr && paddr_in == ADDR_DATE_VALUE && wren_q;
            if (tm_wr)
                time_wdata_out <= {pwdata_in[31:8], 8'h00};
            if (wr && paddr_in == ADDR_DATE_VALUE && wren_q)
                date_wdata_out <= {pwdata_in[31:8], 4'h0,
                                   pwdata_in[WDAY_LSB+:4]};
        end
    end

    // ****************************************************
    // Alarm unit.
    // ****************************************************

    // Masked compare, taken once the calendar shows the new time.
    always_comb
    begin
        logic s_u, s, m_u, m, h, wd, dy, mo;
        s_u = cal_time_in[SEC_LSB+:4] == atime_q[SEC_LSB+:4];
        s   = cal_time_in[SEC_LSB+:8] == atime_q[SEC_LSB+:8];
        m_u = cal_time_in[MIN_LSB+:4] == atime_q[MIN_LSB+:4];
        m   = cal_time_in[MIN_LSB+:8] == atime_q[MIN_LSB+:8];
        h   = cal_time_in[HR_LSB+:8]  == atime_q[HR_LSB+:8];
        wd  = cal_date_in[WDAY_LSB+:4] == adate_q[WDAY_LSB+:4];
        dy  = cal_date_in[SEC_LSB+:8] == adate_q[SEC_LSB+:8];
        mo  = cal_date_in[MIN_LSB+:8] == adate_q[MIN_LSB+:8];
        case (mask_q) // R15 R23
            MASK_HALF:    match = roll_q[1];
            MASK_SEC:     match = sec_q[1];
            MASK_TEN_SEC: match = sec_q[1] & s_u;
            MASK_MIN:     match = sec_q[1] & s;
            MASK_TEN_MIN: match = sec_q[1] & s & m_u;
            MASK_HOUR:    match = sec_q[1] & s & m;
            MASK_DAY:     match = sec_q[1] & s & m & h;
            MASK_WEEK:    match = sec_q[1] & s & m & h & wd;
            MASK_MONTH:   match = sec_q[1] & s & m & h & dy;
            MASK_YEAR:    match = sec_q[1] & s & m & h & dy & mo; // R16
            default:      match = 1'b0;
        endcase
    end

    assign alarm_ev = en_q & match;

    // Alarm compare values.
    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            atime_q <= '0;
            adate_q <= '0;
        end
        else
        begin
            if (wr && paddr_in == ADDR_ALARM_TIME && time_ok(pwdata_in))
                atime_q <= {pwdata_in[31:8], 8'h00}; // R22
            if (wr && paddr_in == ADDR_ALARM_DATE)
                adate_q <= {8'h00, pwdata_in[23:8], 4'h0,
                            pwdata_in[WDAY_LSB+:4]};
        end
    end

    // Alarm control; a software write wins over a same-cycle event.
    always_ff @(posedge ref_clk_in or negedge rstn_in) // R8
    begin
        if (!rstn_in)
        begin
            en_q    <= 1'b0;
            chime_q <= 1'b0;
            pulse_q <= 1'b0;
            mask_q  <= MASK_RESET;
            rpt_q   <= RPT_RESET;
        end
        else if (ac_wr)
        begin
            en_q    <= pwdata_in[AC_EN_BIT];
            chime_q <= pwdata_in[AC_CHIME_BIT];
            mask_q  <= pwdata_in[AC_MASK_LSB+:4];
            rpt_q   <= pwdata_in[AC_RPT_LSB+:8];
            if (!en_q)
                pulse_q <= pwdata_in[AC_PIV_BIT]; // R12
        end
        else if (alarm_ev)
        begin
            pulse_q <= ~pulse_q;
            if (rpt_q != RPT_LAST)
                rpt_q <= rpt_q - 8'h01; // R11
            else if (chime_q)
                rpt_q <= RPT_WRAP; // R10
            else
                en_q <= 1'b0; // R9
        end
    end

    // Pin drive and the seconds tick for the calendar.
    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rtc_pin_out     <= 1'b0;
            rtc_pin_oe_out  <= 1'b0;
            second_tick_out <= 1'b0;
        end
        else
        begin
            rtc_pin_out     <= oe_q & (sel_q ? half_q : pulse_q); // R7
            rtc_pin_oe_out  <= oe_q; // R7
            second_tick_out <= roll & half_q;
        end
    end

    // ****************************************************
    // Assertions.
    // ****************************************************

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);

    a_wren_locked: assert property ( // R2
        cc_wr && pwdata_in[CC_WREN_BIT] && lock_q != LK_OPEN && !wren_q
        |=> !wren_q) else $error("write enable set without unlock");
    a_time_locked: assert property ( // R1
        time_load_out |-> $past(wren_q))
        else $error("time loaded while locked");
    a_on_gated: assert property ( // R3
        cc_wr && !wren_q |=> $stable(on_q))
        else $error("on bit changed while locked");
    a_rsync_roll: assert property ( // R4
        roll |-> near ##1 !near) else $error("rollover outside sync window");
    a_half_clear: assert property ( // R6
        time_load_out |-> !half_q) else $error("half flag not cleared");
    a_pin_off: assert property ( // R7
        !oe_q |=> !rtc_pin_out && !rtc_pin_oe_out)
        else $error("pin driven while output disabled");
    a_alarm_stop: assert property ( // R9
        alarm_ev && !ac_wr && rpt_q == RPT_LAST && !chime_q |=> !en_q)
        else $error("alarm enable not cleared");
    a_rpt_wrap: assert property ( // R10
        alarm_ev && !ac_wr && rpt_q == RPT_LAST && chime_q
        |=> rpt_q == RPT_WRAP && en_q) else $error("repeat count no wrap");
    a_rpt_dec: assert property ( // R11
        alarm_ev && !ac_wr && rpt_q != RPT_LAST
        |=> rpt_q == $past(rpt_q) - 8'h01) else $error("no decrement");
    a_piv_hold: assert property ( // R12
        en_q && !alarm_ev |=> $stable(pulse_q))
        else $error("pulse level changed without event");
    a_ac_upper: assert property ( // R21
        psel_in && !penable_in && !pwrite_in
        && paddr_in == ADDR_ALARM_CONTROL |=> prdata_out[31:16] == 16'h0000)
        else $error("alarm control upper bits not zero");
    a_mask_rsvd: assert property ( // R15
        mask_q > MASK_YEAR |-> !alarm_ev) else $error("reserved mask fired");
    a_bcd_load: assert property ( // R22
        time_load_out |-> time_ok(time_wdata_out))
        else $error("non-BCD time loaded");

    c_chime_wrap: cover property (alarm_ev && chime_q && rpt_q == RPT_LAST);
    c_alarm_stop: cover property (alarm_ev && !chime_q && rpt_q == RPT_LAST);
    c_unlock:     cover property (cc_wr && lock_q == LK_OPEN);
    c_time_load:  cover property (time_load_out);

endmodule : rtc_alarm_ctrl

// *** verif/tb_top.sv ***
`timescale 1ns/1ns

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end

module tb_top
    import rtc_pkg::*;
;
    // ****************************************************
    // Signals, counters and the design.
    // ****************************************************
    logic        ref_clk_in;
    logic        rstn_in;
    logic        rtc_clk_in = 1'b0;
    logic        psel_in;
    logic        penable_in;
    logic        pwrite_in;
    logic [7:0]  paddr_in;
    logic [31:0] pwdata_in;
    logic [31:0] cal_time_in;
    logic [31:0] cal_date_in;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic        rtc_pin_out;
    logic        rtc_pin_oe_out;
    logic        time_load_out;
    logic [31:0] time_wdata_out;
    logic        second_tick_out;
    logic        date_load_out;
    logic [31:0] date_wdata_out;
    logic [31:0] rdat;
    logic        rerr;
    logic [31:0] ld_data;
    logic        pin_q;
    logic [3:0]  m;
    int          failures;
    int          checks;
    int          loads;
    int          toggles;
    int          t0;
    int          cyc;
    int          secs;
    int          s0;

    rtc_alarm_ctrl #(.HALF_SEC_TICKS(80)) u_rtc_alarm_ctrl
    (
        .ref_clk_in,
        .rstn_in,
        .rtc_clk_in,
        .psel_in,
        .penable_in,
        .pwrite_in,
        .paddr_in,
        .pwdata_in,
        .cal_time_in,
        .cal_date_in,
        .prdata_out,
        .pready_out,
        .pslverr_out,
        .rtc_pin_out,
        .rtc_pin_oe_out,
        .second_tick_out,
        .time_load_out,
        .time_wdata_out,
        .date_load_out,
        .date_wdata_out
    );

    // The bus clock runs at 8 ns; the time base comes from the monitor.
    initial
    begin
        ref_clk_in = 1'b0;
        forever #4 ref_clk_in = ~ref_clk_in;
    end

    // Monitors count loads, toggles, seconds and cycles for the timeout.
    // The time base toggles every other cycle, driven on the rising edge.
    always @(posedge ref_clk_in)
    begin
        cyc++;
        pin_q <= rtc_pin_out;
        if (cyc % 2 == 0)
            rtc_clk_in <= ~rtc_clk_in;
        if (second_tick_out === 1'b1)
            secs <= secs + 1;
        if (time_load_out === 1'b1)
        begin
            loads++;
            ld_data <= time_wdata_out;
        end
        if (rtc_pin_out !== pin_q)
            toggles++;
        if (cyc == 50000)
        begin
            failures++;
            results();
        end
    end

    // ****************************************************
    // Bus tasks.
    // ****************************************************
    // One transfer: setup, access held until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge ref_clk_in);
        penable_in <= 1'b1;
        // Data and error are taken at the edge that sees pready high.
        @(posedge ref_clk_in);
        while (pready_out !== 1'b1)
            @(posedge ref_clk_in);
        rdat = prdata_out;
        rerr = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rd

    // Rereads a register until one bit takes the wanted value.
    task automatic poll(input logic [7:0] a, input int b, input logic v);
        int n;
        n = 0;
        rd(a);
        while (rdat[b] !== v && n < 2000)
        begin
            rd(a);
            n++;
        end
        `CHK(rdat[b], v)
    endtask : poll

    // Alarm control is written only while its sync flag is low.
    task automatic wr_alarm(input logic [31:0] d);
        poll(ADDR_ALARM_CONTROL, AC_SYNC_BIT, 1'b0);
        wr(ADDR_ALARM_CONTROL, d);
    endtask : wr_alarm

    task automatic open_wr(input logic [31:0] d);
        wr(ADDR_UNLOCK, UNLOCK_KEY1);
        wr(ADDR_UNLOCK, UNLOCK_KEY2);
        wr(ADDR_CLOCK_CONTROL, d);
    endtask : open_wr

    task automatic results();
        if (failures == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    // ****************************************************
    // Main sequence.
    // ****************************************************
    initial
    begin
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
        cal_time_in = 32'h123456ff;
        cal_date_in = 32'h24022953;
        rstn_in = 1'b0;
        repeat (6) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        rd(ADDR_CLOCK_CONTROL);
        `CHK(rdat, 32'h0)
        rd(ADDR_ALARM_CONTROL);
        `CHK(rdat, 32'h0)
        rd(8'h1c);
        `CHK({rerr, rdat}, 33'h100000000)
        rd(ADDR_TIME_VALUE);
        `CHK(rdat, 32'h12345600)
        rd(ADDR_TIME_VALUE);
        `CHK(rdat, 32'h12345600)
        rd(ADDR_DATE_VALUE);
        `CHK(rdat, 32'h24022903)
        wr(ADDR_CLOCK_CONTROL, 32'h00008009);
        rd(ADDR_CLOCK_CONTROL);
        `CHK(rdat, 32'h00000001)
        wr(ADDR_TIME_VALUE, 32'h12000000);
        repeat (3) @(posedge ref_clk_in);
        `CHK(loads, 0)
        open_wr(32'h00000009);
        rd(ADDR_CLOCK_CONTROL);
        `CHK(rdat, 32'h00000009)
        `CHK(rtc_pin_oe_out, 1'b1)
        wr(ADDR_TIME_VALUE, 32'h00600000);
        wr(ADDR_TIME_VALUE, 32'h235959ff);
        repeat (3) @(posedge ref_clk_in);
        `CHK(loads, 1)
        `CHK(ld_data, 32'h23595900)
        wr(ADDR_CLOCK_CONTROL, 32'h00008009);
        rd(ADDR_CLOCK_CONTROL);
        `CHK(rdat & 32'hfffffff1, 32'h00008041)
        poll(ADDR_CLOCK_CONTROL, CC_HALF_BIT, 1'b1);
        open_wr(32'h00008009);
        wr(ADDR_TIME_VALUE, 32'h00000000);
        wr(ADDR_CLOCK_CONTROL, 32'h0000800b);
        rd(ADDR_CLOCK_CONTROL);
        `CHK(rdat[CC_HALF_BIT], 1'b0)
        wr(ADDR_DATE_VALUE, 32'h250314f6);
        @(posedge ref_clk_in);
        `CHK({date_load_out, date_wdata_out}, 33'h125031406)
        t0 = toggles;
        wr_alarm(32'h00008002);
        poll(ADDR_ALARM_CONTROL, AC_EN_BIT, 1'b0);
        repeat (2) @(posedge ref_clk_in);
        `CHK(toggles - t0, 3)
        `CHK(rdat & 32'hffffcfff, 32'h0)
        s0 = secs;
        repeat (640) @(posedge ref_clk_in);
        `CHK(secs - s0, 1)
        repeat (260) @(posedge ref_clk_in);
        `CHK(toggles - t0, 3)
        wr_alarm(32'h0000c000);
        poll(ADDR_ALARM_CONTROL, 0, 1'b1);
        `CHK(rdat & 32'hffffcfff, 32'h0000c0ff)
        rd(ADDR_ALARM_CONTROL);
        `CHK(rdat[7:0], 8'hff)
        wr_alarm(32'h0);
        wr_alarm(32'hffff2300);
        rd(ADDR_ALARM_CONTROL);
        `CHK(rdat & 32'hffffefff, 32'h00002300)
        for (m = 4'h0; m <= 4'h9; m++)
        begin
            wr_alarm({20'h0, m, 8'h00});
            rd(ADDR_ALARM_CONTROL);
            `CHK(rdat[11:8], m)
        end
        wr(ADDR_CLOCK_CONTROL, 32'h00008000);
        repeat (2) @(posedge ref_clk_in);
        `CHK({rtc_pin_oe_out, rtc_pin_out}, 2'b00)
        results();
    end

endmodule : tb_top
